//--- design/pmc_hold_timer.sv
// Purpose: counts a fixed hold time after a start pulse
// Assumes: start only while not busy
// Notes:   done pulses in the last busy cycle
`timescale 1ns/100ps
module pmc_hold_timer #(
   parameter int CYCLES = 8
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic start,
   output logic      done
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES);

   logic [CW-1:0] count_r;
   logic          running_r;

   assign done = running_r && (count_r == LAST);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_r   <= '0;
         running_r <= 1'b0;
      end else if (start) begin
         count_r   <= CW'(1);
         running_r <= 1'b1;
      end else if (done) begin
         running_r <= 1'b0;
      end else if (running_r) begin
         count_r   <= count_r + CW'(1);
      end
   end

endmodule

//--- design/pmc_phy_mode_control.sv
// Purpose: phy mode control register with self-clearing reset and restart
// Assumes: requests synchronous to clk, one per cycle
// Notes:   writes are ignored while a soft reset is in progress
`timescale 1ns/100ps
module pmc_phy_mode_control #(
   parameter int SOFT_RESET_CYCLES = pmc_pkg::SOFT_RESET_CYCLES
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire pmc_pkg::pmc_req_t req,
   output pmc_pkg::pmc_rsp_t     rsp,
   output pmc_pkg::pmc_mode_t    mode,
   output logic                  autonegRestart,
   output logic                  stateInit
);

   // ------------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------------
   pmc_pkg::pmc_sr_state_t srState_r;
   pmc_pkg::pmc_sr_state_t srState_nxt;
   logic [15:0]            ctl_r;
   logic [15:0]            ctl_nxt;
   logic                   restartPend_r;
   logic                   restartPend_nxt;
   pmc_pkg::pmc_rsp_t      rsp_r;
   pmc_pkg::pmc_rsp_t      rsp_nxt;
   logic                   srDone;
   logic                   srBusy;
   logic                   ctlHit;
   logic                   ctlWrite;
   logic                   softResetReq;
   logic [15:0]            ctlView;

   assign srBusy       = (srState_r == pmc_pkg::SR_HOLD);
   assign ctlHit       = req.valid && (req.index == pmc_pkg::CTRL_INDEX);
   assign ctlWrite     = ctlHit && req.write && !srBusy;
   assign softResetReq = ctlWrite && req.data[pmc_pkg::SOFT_RESET_BIT];

   // ------------------------------------------------------------------
   // soft reset sequencing
   // ------------------------------------------------------------------
   pmc_hold_timer #(
      .CYCLES (SOFT_RESET_CYCLES)
   ) u_timer (
      .clk     (clk),
      .reset_n (reset_n),
      .start   (softResetReq),
      .done    (srDone)
   );

   always_comb begin
      srState_nxt = srState_r;
      unique case (srState_r)
         pmc_pkg::SR_IDLE: begin
            if (softResetReq) begin
               srState_nxt = pmc_pkg::SR_HOLD; // RL1
            end
         end
         pmc_pkg::SR_HOLD: begin
            if (srDone) begin
               srState_nxt = pmc_pkg::SR_IDLE; // RL2
            end
         end
      endcase
   end

   // ------------------------------------------------------------------
   // control storage
   // ------------------------------------------------------------------
   always_comb begin
      ctl_nxt = ctl_r;
      if (softResetReq || srBusy) begin
         ctl_nxt = pmc_pkg::CTRL_RESET; // RL1
      end else if (ctlWrite) begin
         ctl_nxt = req.data & pmc_pkg::CTRL_RW_MASK; // RL8
      end
   end

   // restart flag lives one cycle, then clears itself
   assign restartPend_nxt = ctlWrite && !softResetReq &&
                            req.data[pmc_pkg::ANEG_RST_BIT]; // RL3 RL4

   // ------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------
   always_comb begin
      ctlView = ctl_r & pmc_pkg::CTRL_RW_MASK;
      ctlView[pmc_pkg::SOFT_RESET_BIT] = srBusy; // RL2
      ctlView[pmc_pkg::ANEG_RST_BIT]   = restartPend_r; // RL4
   end

   always_comb begin
      rsp_nxt.valid = req.valid && !req.write;
      rsp_nxt.data  = 16'h0000;
      if (req.valid && !req.write && ctlHit) begin
         rsp_nxt.data = ctlView; // RL5 RL7
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         srState_r     <= pmc_pkg::SR_IDLE;
         ctl_r         <= pmc_pkg::CTRL_RESET; // RL5 RL6
         restartPend_r <= 1'b0;
         rsp_r         <= '0;
      end else begin
         srState_r     <= srState_nxt;
         ctl_r         <= ctl_nxt;
         restartPend_r <= restartPend_nxt;
         rsp_r         <= rsp_nxt;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign rsp                   = rsp_r;
   assign autonegRestart        = restartPend_r; // RL3
   assign stateInit             = srBusy; // RL1
   assign mode.loopBackSelect   = ctl_r[pmc_pkg::LOOPBACK_BIT]; // RL8
   assign mode.speedSelect      = ctl_r[pmc_pkg::SPEED_BIT];
   assign mode.autonegEnable    = ctl_r[pmc_pkg::ANEG_EN_BIT];
   assign mode.powerDownRequest = ctl_r[pmc_pkg::POWER_DOWN_REQUEST_BIT];
   assign mode.isolate          = ctl_r[pmc_pkg::ISOLATE_BIT];
   assign mode.fullDuplex       = ctl_r[pmc_pkg::DUPLEX_BIT];
   assign mode.collisionTest    = ctl_r[pmc_pkg::COLTEST_BIT];

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   logic [15:0] reqData_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reqData_q <= 16'h0000;
      end else begin
         reqData_q <= req.data;
      end
   end

   // length of the current init hold, in cycles
   logic [4:0] holdLen_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         holdLen_q <= 5'h00;
      end else if (stateInit) begin
         holdLen_q <= holdLen_q + 5'h01;
      end else begin
         holdLen_q <= 5'h00;
      end
   end

   sequence s_sr_start;
      softResetReq;
   endsequence

   sequence s_sr_finish;
      stateInit ##[1:16] !stateInit;
   endsequence

   sequence s_restart_req;
      ctlWrite && !softResetReq && req.data[pmc_pkg::ANEG_RST_BIT];
   endsequence

   a_sr_defaults: assert property ( // RL1
      s_sr_start |=> (ctl_r == pmc_pkg::CTRL_RESET) && stateInit)
      else $error("soft reset did not restore defaults");

   a_sr_selfclear: assert property ( // RL2
      s_sr_start |=> s_sr_finish)
      else $error("soft reset bit did not clear");

   a_sr_hold_len: assert property ( // RL2
      $fell(stateInit) |-> (holdLen_q == 5'(SOFT_RESET_CYCLES)))
      else $error("soft reset hold length wrong");

   a_sr_read_busy: assert property ( // RL2
      (ctlHit && !req.write && stateInit) |=>
         rsp.data[pmc_pkg::SOFT_RESET_BIT])
      else $error("reset bit not shown during hold");

   a_sr_no_restart: assert property ( // RL1
      s_sr_start |=> !autonegRestart)
      else $error("restart issued with soft reset");

   a_sr_ignore_wr: assert property ( // RL1
      (srBusy && !srDone && req.valid && req.write) |=>
         (ctl_r == pmc_pkg::CTRL_RESET))
      else $error("write taken during soft reset");

   a_restart_pulse: assert property ( // RL3
      s_restart_req |=>
         autonegRestart ##1 (!autonegRestart || $past(restartPend_nxt)))
      else $error("restart pulse wrong");

   a_restart_clear: assert property ( // RL4
      autonegRestart |->
         $past(ctlWrite && req.data[pmc_pkg::ANEG_RST_BIT]))
      else $error("restart bit stuck");

   a_read_ctrl: assert property ( // RL5
      (ctlHit && !req.write) |=>
         rsp.valid && (rsp.data[8:7] == $past(ctl_r[8:7])) &&
         (rsp.data[6:0] == 7'h00))
      else $error("control read data wrong");

   a_sr_normal: assert property ( // RL6
      s_sr_start |=> !mode.loopBackSelect && !mode.powerDownRequest &&
         !mode.isolate && mode.autonegEnable)
      else $error("defaults not normal operation");

   a_read_other: assert property ( // RL7
      (req.valid && !req.write && !ctlHit) |=>
         rsp.valid && (rsp.data == 16'h0000))
      else $error("unmapped read not zero");

   a_write_other: assert property ( // RL5
      (req.valid && req.write && !ctlHit && !srBusy) |=> $stable(ctl_r))
      else $error("unmapped write changed control");

   a_mode_write: assert property ( // RL8
      (ctlWrite && !softResetReq) |=>
         (mode.loopBackSelect == reqData_q[pmc_pkg::LOOPBACK_BIT]) &&
         (mode.fullDuplex == reqData_q[pmc_pkg::DUPLEX_BIT]))
      else $error("mode bit not stored");

endmodule

//--- design/pmc_pkg.sv
// Purpose: shared constants and types for the phy mode control register
// Assumes: 125 MHz clk, register access by single-cycle management request
// Notes:   one request per cycle at most, answer one cycle later
//
// Functional notes
// RL1 - writing one to bit 15 restores defaults and resets state machines
// RL2 - hardware clears the soft-reset bit once the reset has completed
// RL3 - writing one to bit 9 restarts auto-negotiation from its start
// RL4 - restart bit clears itself as soon as the restart is issued
// RL5 - control register at index 0x00, read/write, resets to 0x3100
// RL6 - default settings give normal operation without any configuration
// RL7 - controller addresses registers by five-bit index with read/write flag
// RL8 - mode bits are plain read/write controls that drive phy modes
package pmc_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [4:0]  CTRL_INDEX     = 5'h00;
   localparam logic [15:0] CTRL_RESET     = 16'h3100;
   localparam logic [15:0] CTRL_RW_MASK   = 16'h7d80;
   localparam int          SOFT_RESET_BIT = 15;
   localparam int          LOOPBACK_BIT   = 14;
   localparam int          SPEED_BIT      = 13;
   localparam int          ANEG_EN_BIT    = 12;
   localparam int          POWER_DOWN_REQUEST_BIT      = 11;
   localparam int          ISOLATE_BIT    = 10;
   localparam int          ANEG_RST_BIT   = 9;
   localparam int          DUPLEX_BIT     = 8;
   localparam int          COLTEST_BIT    = 7;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ       = 125;
   localparam int SOFT_RESET_NS = 64;
   localparam int SOFT_RESET_CYCLES =
      (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [4:0]  index;
      logic [15:0] data;
   } pmc_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } pmc_rsp_t;

   typedef struct packed {
      logic loopBackSelect;
      logic speedSelect;
      logic autonegEnable;
      logic powerDownRequest;
      logic isolate;
      logic fullDuplex;
      logic collisionTest;
   } pmc_mode_t;

   typedef enum logic {
      SR_IDLE = 1'b0,
      SR_HOLD = 1'b1
   } pmc_sr_state_t;

endpackage

//--- dv/phy_control_register_test.sv
// Purpose: self-checking bench for the phy mode control register
// Assumes: 125 MHz clk, short soft-reset hold via parameter
// Notes:   read answers scored from a queue of expected words
`timescale 1ns/100ps
module phy_control_register_test;
   localparam int HOLD = 4;
   logic               clk;
   logic               reset_n;
   pmc_pkg::pmc_req_t  req;
   pmc_pkg::pmc_rsp_t  rsp;
   pmc_pkg::pmc_mode_t mode;
   logic               autonegRestart;
   logic               stateInit;
   int                 bad_count = 0;
   int                 tests_run = 0;
   logic [15:0]        expQ[$];
   logic [15:0]        v;
   // ------------------------------------------------------------
   // instances
   // ------------------------------------------------------------
   pmc_phy_mode_control #(.SOFT_RESET_CYCLES(HOLD)) dut_u (
      .clk(clk), .reset_n(reset_n), .req(req), .rsp(rsp), .mode(mode),
      .autonegRestart(autonegRestart), .stateInit(stateInit));
   pmc_mgmt_model mm_u (.clk(clk), .req(req));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] mw(input logic [15:0] d);
      return {9'h0, d[14], d[13], d[12], d[11], d[10], d[8], d[7]};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [4:0] idx, input logic [15:0] e);
      expQ.push_back(e);
      mm_u.xfer(1'b0, idx, 16'h0000);
   endtask
   task automatic wr(input logic [15:0] d);
      mm_u.xfer(1'b1, 5'h00, d);
   endtask
   task automatic close_out;
      chk("pending reads", 16'h0000, 16'(expQ.size()));
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // read answers taken off the queue in order
   always @(posedge clk) begin
      if (rsp.valid === 1'b1) begin
         if (expQ.size() == 0)
            chk("rsp.valid", 16'h0000, 16'h0001);
         else
            chk("rsp.data", expQ.pop_front(), rsp.data);
      end
   end
   initial begin
      #(20000 * 8);
      bad_count++;
      close_out;
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      void'($urandom(99986));
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      chk("mode", mw(16'h3100), {9'h0, mode});
      rd(5'h00, 16'h3100);
      rd(5'($urandom_range(31, 1)), 16'h0000);
      v = 16'($urandom) & 16'h7dff;
      wr(v);
      rd(5'h00, v & 16'h7d80);
      mm_u.idle(1);
      chk("mode", mw(v), {9'h0, mode});
      v = v & 16'h7d80;
      wr(v | 16'h0200);
      mm_u.idle(1);
      chk("autonegRestart", 16'h0001, {15'h0, autonegRestart});
      mm_u.idle(1);
      chk("autonegRestart", 16'h0000, {15'h0, autonegRestart});
      mm_u.xfer(1'b1, 5'($urandom_range(31, 1)), ~v & 16'h7d80);
      rd(5'h00, v);
      wr(16'h8000 | (16'($urandom) & 16'h7dff));
      mm_u.idle(1);
      chk("stateInit", 16'h0001, {15'h0, stateInit});
      chk("mode", mw(16'h3100), {9'h0, mode});
      wr(16'h4000);
      rd(5'h00, 16'hb100);
      mm_u.idle(HOLD);
      chk("stateInit", 16'h0000, {15'h0, stateInit});
      rd(5'h00, 16'h3100);
      mm_u.idle(3);
      close_out;
   end
endmodule

//--- dv/pmc_mgmt_model.sv
// Purpose: management controller model issuing register requests
// Assumes: requests launched on rising clk edges
// Notes:   one request per call, held for exactly one edge
`timescale 1ns/100ps
module pmc_mgmt_model (
   input  wire logic         clk,
   output pmc_pkg::pmc_req_t req
);
   // ------------------------------------------------------------
   // request driver
   // ------------------------------------------------------------
   initial req = '0;
   task automatic xfer(input logic w, input logic [4:0] idx,
                       input logic [15:0] d);
      req <= '{valid: 1'b1, write: w, index: idx, data: d};
      @(posedge clk);
   endtask
   // slow controller: idle gaps between requests
   task automatic idle(input int n);
      req <= '0;
      repeat (n) @(posedge clk);
   endtask
endmodule
